// *** logic/arr_pkg.sv ***
// shared constants for the conversion result register block
package arr_pkg;
  localparam int RESULT_WIDTH = 10;
  localparam int ADDR_WIDTH   = 3;
  // consecutive byte addresses of the registers, one per register
  localparam logic [2:0] OFFSET_RESULT_LOW  = 3'h0;
  localparam logic [2:0] OFFSET_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OFFSET_INPUT_SEL   = 3'h2;
  localparam logic [2:0] OFFSET_STATUS      = 3'h3;
  // input selection register fields
  localparam int SEL_ALIGN_BIT = 5;
  localparam int SEL_CHAN_LSB  = 0;
  localparam int SEL_CHAN_MSB  = 3;
  localparam logic [7:0] SEL_WRITE_MASK = 8'hef;
  localparam logic [7:0] SEL_RESET      = 8'h00;
  // status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_CHAN_MSB = 7;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  typedef enum logic [0:0] {
    ARR_OPEN   = 1'b0,
    ARR_LOCKED = 1'b1
  } arr_lock_type;
endpackage : arr_pkg

// *** logic/arr_result_store.sv ***
// holds the raw conversion result and its channel, with load gating
`timescale 1ns/1ns
module arr_result_store #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk,
  input  wire logic             rstSync_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadData,
  input  wire logic [3:0]       loadChan,
  output logic      [WIDTH-1:0] storedData,
  output logic      [3:0]       storedChan
);
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      storedData <= '0;
      storedChan <= 4'h0;
    end else if (load) begin
      storedData <= loadData;
      storedChan <= loadChan;
    end
  end
endmodule : arr_result_store

// *** logic/adc_result_register_access.sv ***
// conversion result register pair with alignment and read lock, Avalon-MM slave
//
// Function
// - alignment clear puts bits 9:8 low in high byte, 7:0 in low byte.
// - alignment set puts bits 9:2 in high byte, 1:0 at low byte bits 7:6.
// - result field is ten bits across the sixteen-bit byte pair.
// - completed conversion value loads into the result pair on completion while unlocked and no low byte read is captured in that cycle.
// - low byte read locks both bytes until high byte read releases it.
// - presentation follows the alignment setting of input selection; channel bits only go to status with the stored result.
// - changing alignment alters presentation immediately, even mid-conversion.
// - done flag sets together with the result register update.
`timescale 1ns/1ns
module adc_result_register_access #(
  parameter int RESULT_WIDTH = arr_pkg::RESULT_WIDTH
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [arr_pkg::ADDR_WIDTH-1:0] avsAddress,
  input  wire logic                           avsRead,
  input  wire logic                           avsWrite,
  input  wire logic [7:0]                     avsWritedata,
  output logic      [7:0]                     avsReaddata,
  output logic                                avsWaitrequest,
  input  wire logic                           convDone,
  input  wire logic [RESULT_WIDTH-1:0]        convData,
  output logic      [3:0]                     channelSelect,
  output logic                                conversionDoneFlag
);
  // zero fill that pads the result out to the sixteen-bit pair
  localparam int PAD_WIDTH = 16 - RESULT_WIDTH;

  logic                    rstMeta_n;
  logic                    rstSync_n;
  logic                    readAck;
  logic                    firstCycle;
  logic                    selLow;
  logic                    selHigh;
  logic                    selInputSel;
  logic                    selStatus;
  logic                    rdLow;
  logic                    rdHigh;
  logic                    wrTaken;

  logic [7:0]              inputSelectRegister;
  logic                    leftAlignSelect;
  arr_pkg::arr_lock_type   lockState;
  logic                    loadOk;
  logic [RESULT_WIDTH-1:0] storedData;
  logic [3:0]              storedChan;

  logic [15:0]             rightView;
  logic [15:0]             leftView;
  logic [15:0]             pairView;
  logic [7:0]              statusWord;
  logic [7:0]              next_readdata;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // everything below runs on the released copy of reset
  // one wait cycle per access, answer on the second edge
  // a request held across the answer edge starts a fresh wait cycle
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      readAck <= 1'b0;
    end else begin
      readAck <= (avsRead || avsWrite) && !readAck;
    end
  end
  assign firstCycle     = (avsRead || avsWrite) && !readAck;
  assign avsWaitrequest = firstCycle;

  function automatic logic hitAddr(input logic [arr_pkg::ADDR_WIDTH-1:0] a, input logic [2:0] o);
    hitAddr = (a == o);
  endfunction : hitAddr

  // register decode, shared by the read and write sides
  assign selLow      = hitAddr(avsAddress, arr_pkg::OFFSET_RESULT_LOW);
  assign selHigh     = hitAddr(avsAddress, arr_pkg::OFFSET_RESULT_HIGH);
  assign selInputSel = hitAddr(avsAddress, arr_pkg::OFFSET_INPUT_SEL);
  assign selStatus   = hitAddr(avsAddress, arr_pkg::OFFSET_STATUS);

  // read data and lock move on the first cycle of a read, so the byte
  // returned and the lock it sets come from one stored value
  assign rdLow   = avsRead && firstCycle && selLow;
  assign rdHigh  = avsRead && firstCycle && selHigh;
  assign wrTaken = avsWrite && readAck;

  //////////////////////////////////////////////////////////////////////////////
  // bit four is not writable and reads zero
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      inputSelectRegister <= arr_pkg::SEL_RESET;
    end else if (wrTaken && selInputSel) begin
      inputSelectRegister <= avsWritedata & arr_pkg::SEL_WRITE_MASK;
    end
  end
  assign leftAlignSelect = inputSelectRegister[arr_pkg::SEL_ALIGN_BIT];
  assign channelSelect   = inputSelectRegister[arr_pkg::SEL_CHAN_MSB:arr_pkg::SEL_CHAN_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // lock: a high read in the same cycle as a low read cannot happen on one bus
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lockState <= arr_pkg::ARR_OPEN;
    end else begin
      case (lockState)
        arr_pkg::ARR_OPEN: begin
          if (rdLow) begin
            lockState <= arr_pkg::ARR_LOCKED;
          end
        end
        arr_pkg::ARR_LOCKED: begin
          if (rdHigh) begin
            lockState <= arr_pkg::ARR_OPEN;
          end
        end
        default: lockState <= arr_pkg::ARR_OPEN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completions while locked are dropped, not queued; one that meets the
  // low-byte capture is dropped too, or the two bytes would disagree
  assign loadOk = convDone && (lockState == arr_pkg::ARR_OPEN) && !rdLow;

  // the channel is stored with the value, so status names its source
  arr_result_store #(
    .WIDTH(RESULT_WIDTH)
  ) u_store (
    .clk        (clk),
    .rstSync_n  (rstSync_n),
    .load       (loadOk),
    .loadData   (convData),
    .loadChan   (channelSelect),
    .storedData (storedData),
    .storedChan (storedChan)
  );

  //////////////////////////////////////////////////////////////////////////////
  // done flag sets with the load; write one clears; set wins over clear
  // clearing needs a one in the done bit, zeros leave the flag alone
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      conversionDoneFlag <= 1'b0;
    end else if (loadOk) begin
      conversionDoneFlag <= 1'b1;
    end else if (wrTaken && selStatus && avsWritedata[arr_pkg::STAT_DONE_BIT]) begin
      conversionDoneFlag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit placement for both alignments, fixed by the width parameter
  for (genvar g = 0; g < 16; g++) begin : g_view
    if (g < RESULT_WIDTH) begin : g_right_data
      assign rightView[g] = storedData[g];
    end else begin : g_right_pad
      assign rightView[g] = 1'b0;
    end
    if (g >= PAD_WIDTH) begin : g_left_data
      assign leftView[g] = storedData[g-PAD_WIDTH];
    end else begin : g_left_pad
      assign leftView[g] = 1'b0;
    end
  end

  // presentation is combinational on the live alignment bit
  always_comb begin
    if (leftAlignSelect) begin
      pairView = leftView;
    end else begin
      pairView = rightView;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status: done flag, lock state and the channel the held result came from
  always_comb begin
    statusWord = 8'h00;
    statusWord[arr_pkg::STAT_DONE_BIT] = conversionDoneFlag;
    statusWord[arr_pkg::STAT_LOCK_BIT] = (lockState == arr_pkg::ARR_LOCKED);
    statusWord[arr_pkg::STAT_CHAN_MSB:arr_pkg::STAT_CHAN_LSB] = storedChan;
  end

  // unmapped words read zero
  always_comb begin
    next_readdata = 8'h00;
    if (selLow) begin
      next_readdata = pairView[7:0];
    end else if (selHigh) begin
      next_readdata = pairView[15:8];
    end else if (selInputSel) begin
      next_readdata = inputSelectRegister;
    end else if (selStatus) begin
      next_readdata = statusWord;
    end
  end

  // captured on the first cycle, stands through the answer edge
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      avsReaddata <= 8'h00;
    end else if (avsRead && firstCycle) begin
      avsReaddata <= next_readdata;
    end
  end
endmodule : adc_result_register_access

// *** verification/arr_props.sv ***
// assertion checker for the result register block
`timescale 1ns/1ns
module arr_props #(
  parameter int RESULT_WIDTH = 10
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [2:0]              avsAddress,
  input wire logic                    avsRead,
  input wire logic                    avsWrite,
  input wire logic [7:0]              avsWritedata,
  input wire logic [7:0]              avsReaddata,
  input wire logic                    avsWaitrequest,
  input wire logic                    convDone,
  input wire logic [RESULT_WIDTH-1:0] convData,
  input wire logic [3:0]              channelSelect,
  input wire logic                    conversionDoneFlag
);
  logic                    lockHeld;
  logic                    alignSet;
  logic [RESULT_WIDTH-1:0] heldData;
  logic [3:0]              heldChan;
  wire                     ack = (avsRead | avsWrite) & !avsWaitrequest;
  wire                     lowCap = avsRead & avsWaitrequest & (avsAddress == 3'h0);
  wire                     highCap = avsRead & avsWaitrequest & (avsAddress == 3'h1);
  wire  [3:0]              wdLow = avsWritedata[3:0];
  wire  [7:0]              expStatus = {heldChan, 2'b00, lockHeld, conversionDoneFlag};
  wire  [7:0]              expLow = alignSet ? {heldData[1:0], 6'h00} : heldData[7:0];
  wire  [7:0]              expHigh = alignSet ? heldData[9:2] : {6'h00, heldData[9:8]};
  ////////////////////////////////////////////////////////////////
  // reference copy of lock, alignment and held value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockHeld <= 1'b0;
      alignSet <= 1'b0;
      heldData <= '0;
      heldChan <= 4'h0;
    end else begin
      if (lowCap) lockHeld <= 1'b1;
      if (highCap) lockHeld <= 1'b0;
      if (ack && avsWrite && avsAddress == 3'h2) alignSet <= avsWritedata[5];
      if (convDone && !lockHeld && !lowCap) begin
        heldData <= convData;
        heldChan <= channelSelect;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_first: assert property ($rose(avsRead | avsWrite) |-> avsWaitrequest)
    else $error("request answered without wait");
  a_wait_one: assert property ((avsRead | avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("wait longer than one cycle");
  a_low_byte: assert property (ack && avsRead && avsAddress == 3'h0 |-> avsReaddata == $past(expLow))
    else $error("low byte wrong");
  a_high_byte: assert property (ack && avsRead && avsAddress == 3'h1 |-> avsReaddata == $past(expHigh))
    else $error("high byte wrong");
  a_unmapped_zero: assert property (ack && avsRead && avsAddress[2] |-> avsReaddata == 8'h00)
    else $error("unmapped read not zero");
  a_status_word: assert property (ack && avsRead && avsAddress == 3'h3 |-> avsReaddata == $past(expStatus))
    else $error("status word wrong");
  a_chan_load: assert property (ack && avsWrite && avsAddress == 3'h2 |=> channelSelect == $past(wdLow))
    else $error("channel bits not loaded");
  a_flag_set: assert property (convDone && !lockHeld && !lowCap |=> conversionDoneFlag)
    else $error("done flag not set on load");
  a_flag_cause: assert property ($rose(conversionDoneFlag) |-> $past(convDone) && !$past(lockHeld) && !$past(lowCap))
    else $error("done flag set without load");
  a_flag_clear: assert property (ack && avsWrite && avsAddress == 3'h3 && avsWritedata[0] && !convDone
    |=> !conversionDoneFlag) else $error("done flag not cleared");
endmodule : arr_props
bind adc_result_register_access arr_props #(.RESULT_WIDTH(RESULT_WIDTH)) chk (.clk(clk), .rst_n(rst_n),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .convDone(convDone), .convData(convData),
  .channelSelect(channelSelect), .conversionDoneFlag(conversionDoneFlag));

// *** verification/tb_top.sv ***
// self-checking bench for the result register block
`timescale 1ns/1ns
module tb_top;
  logic       clk, rst_n, avsRead, avsWrite, avsWaitrequest, convDone, conversionDoneFlag;
  logic [2:0] avsAddress;
  logic [7:0] avsWritedata, avsReaddata, rd;
  logic [9:0] convData;
  logic [3:0] channelSelect;
  int         mismatches, comparisons;
  adc_result_register_access uut (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .convDone(convDone), .convData(convData),
    .channelSelect(channelSelect), .conversionDoneFlag(conversionDoneFlag));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // one Avalon transfer; an edge always passes before the next request
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {avsAddress, avsWritedata, avsWrite, avsRead} <= {a, d, wr, !wr};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    if (avsWaitrequest !== 1'b0) begin
      mismatches++;
      close_out();
    end
    rd = avsReaddata;
    {avsWrite, avsRead} <= 2'b00;
  endtask : bus
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rdchk
  task automatic conv(input logic [9:0] d);
    @(posedge clk);
    {convDone, convData} <= {1'b1, d};
    @(posedge clk);
    convDone <= 1'b0;
    @(posedge clk);
  endtask : conv
  ////////////////////////////////////////////////////////////////
  task automatic s_plain;
    rdchk(3'h0, 8'h00);
    rdchk(3'h1, 8'h00);
    conv(10'h2a5);
    check({7'h00, conversionDoneFlag}, 8'h01);
    rdchk(3'h0, 8'ha5);
    rdchk(3'h1, 8'h02);
    bus(1'b1, 3'h3, 8'h01);
    @(posedge clk);
    check({7'h00, conversionDoneFlag}, 8'h00);
    rdchk(3'h5, 8'h00);
    bus(1'b1, 3'h0, 8'hff);
    rdchk(3'h0, 8'ha5);
    rdchk(3'h1, 8'h02);
  endtask : s_plain
  task automatic s_left;
    bus(1'b1, 3'h2, 8'h2b);
    @(posedge clk);
    check({4'h0, channelSelect}, 8'h0b);
    rdchk(3'h2, 8'h2b);
    rdchk(3'h0, 8'h40);
    rdchk(3'h1, 8'ha9);
    conv(10'h155);
    rdchk(3'h1, 8'h55);
    rdchk(3'h3, 8'hb1);
    conv(10'h3ff);
    rdchk(3'h1, 8'hff);
    bus(1'b1, 3'h2, 8'hff);
    rdchk(3'h2, 8'hef);
  endtask : s_left
  task automatic s_lock;
    bus(1'b1, 3'h2, 8'h00);
    conv(10'h1c3);
    rdchk(3'h0, 8'hc3);
    bus(1'b1, 3'h3, 8'h01);
    rdchk(3'h3, 8'h02);
    conv(10'h03c);
    check({7'h00, conversionDoneFlag}, 8'h00);
    rdchk(3'h1, 8'h01);
    conv(10'h03c);
    rdchk(3'h0, 8'h3c);
    rdchk(3'h1, 8'h00);
  endtask : s_lock
  initial begin
    {rst_n, avsRead, avsWrite, convDone, avsAddress, avsWritedata, convData} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_plain();
    s_left();
    s_lock();
    close_out();
  end
endmodule : tb_top
